// File: sim/flash_page_organization_protect_tb_top.sv
// self-checking bench for the flash sequencer driven by its processor-side model
`timescale 1ns/10ps
module flash_page_organization_protect_tb_top;
    logic       clock;        // 25 MHz clock
    logic       resetn;       // synchronous reset, active low
    logic       cmd_valid;    // command strobe
    logic [2:0] cmd;          // command code
    logic [7:0] addr_hi;      // address high byte
    logic [7:0] addr_lo;      // address low byte
    logic [7:0] data;         // data byte
    logic [7:0] key;          // offered key
    logic       busy;         // block busy
    logic       done;         // completion pulse
    logic       error_q;      // refusal flag
    logic       verify_ok_q;  // verify outcome
    logic [7:0] read_data_q;  // last read byte
    logic       err;          // captured refusal
    logic       vok;          // captured verify outcome
    logic [7:0] rd;           // captured read byte
    logic       hung;         // wait ran out
    int         n_errors;     // mismatches
    int         n_compared;   // comparisons

    initial clock = 1'b0;
    always #20 clock = ~clock;

    fpo_ctrl i_fpo_ctrl (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .flash_command_reg(cmd),
        .flash_addr_high_reg(addr_hi), .flash_addr_low_reg(addr_lo), .flash_byte_reg(data), .prot_key_in(key),
        .busy(busy), .done(done), .error_q(error_q), .verify_ok_q(verify_ok_q), .read_data_q(read_data_q));
    fpo_cpu_model i_fpo_cpu_model (.clock(clock), .busy(busy), .done(done), .error_q(error_q),
        .verify_ok_q(verify_ok_q), .read_data_q(read_data_q), .cmd_valid(cmd_valid), .cmd(cmd),
        .addr_hi(addr_hi), .addr_lo(addr_lo), .data(data), .key(key));

    // counts and verdict, the single end of the run
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_flag(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag

    // one command; a hang ends the run at once
    task automatic issue(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d, input logic [7:0] k);
        i_fpo_cpu_model.run_cmd(c, a, d, k, err, vok, rd, hung);
        if (hung !== 1'b0) begin
            n_errors++;
            $display("MISMATCH done expected 1 seen 0");
            wrap_up();
        end
        check_flag("done after its cycle", 1'b0, done);
        check_flag("busy after done", 1'b0, busy);
    endtask : issue

    task automatic rd_chk(input logic [15:0] a, input logic e, input logic [7:0] b);
        issue(fpo_pkg::CMD_READ, a, 8'hA5, 8'h00);
        check_flag("read refused", e, err);
        if (e === 1'b0) check_byte("read byte", b, rd);
    endtask : rd_chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] k, input logic e);
        issue(fpo_pkg::CMD_WRITE, a, d, k);
        check_flag("write refused", e, err);
    endtask : wr

    // array contents are not reset, so everything starts from a mass erase
    task automatic sc_erase_state;
        issue(fpo_pkg::CMD_MASS, 16'h0000, 8'h00, 8'h00);
        check_flag("mass erase refused", 1'b0, err);
        rd_chk(16'h0000, 1'b0, 8'hFF);
        rd_chk(16'hF7FF, 1'b0, 8'hFF);
    endtask : sc_erase_state

    // two programs of one byte leave the AND of both; read back, then verify a match and a mismatch
    task automatic sc_program;
        wr(16'h0010, 8'hA5, 8'h00, 1'b0);
        wr(16'h0010, 8'h5A, 8'h00, 1'b0);
        rd_chk(16'h0010, 1'b0, 8'h00);
        issue(fpo_pkg::CMD_VERIFY, 16'h0010, 8'h00, 8'h00);
        check_flag("verify match", 1'b1, vok);
        issue(fpo_pkg::CMD_VERIFY, 16'h0010, 8'hA5, 8'h00);
        check_flag("verify differ", 1'b0, vok);
    endtask : sc_program

    task automatic sc_page_scope;
        wr(16'h0200, 8'h00, 8'h00, 1'b0);
        issue(fpo_pkg::CMD_ERASE, 16'h0210, 8'h00, 8'h00);
        check_flag("page erase refused", 1'b0, err);
        rd_chk(16'h0200, 1'b0, 8'hFF);
        rd_chk(16'h0010, 1'b0, 8'h00);
        wr(16'hF5FF, 8'h12, 8'h00, 1'b0);
        rd_chk(16'hF5FF, 1'b0, 8'h12);
    endtask : sc_page_scope

    task automatic sc_blocked;
        logic [2:0] bad [3];
        bad = '{3'h0, 3'h6, 3'h7};
        foreach (bad[i]) begin
            issue(bad[i], 16'h0000, 8'h00, 8'h00);
            check_flag("unknown code refused", 1'b1, err);
        end
        rd_chk(16'hF800, 1'b1, 8'h00);
        wr(16'hFFFF, 8'h00, 8'h00, 1'b1);
        issue(fpo_pkg::CMD_ERASE, 16'hF800, 8'h00, 8'h00);
        check_flag("firmware erase refused", 1'b1, err);
    endtask : sc_blocked

    // key, write/erase and read protection, then the top page locked last
    task automatic sc_protection;
        wr(16'hF7EB, 8'h3C, 8'h00, 1'b0);
        wr(16'hF7F0, 8'hFE, 8'h11, 1'b1);
        rd_chk(16'hF7F0, 1'b0, 8'hFF);
        wr(16'hF7EA, 8'h55, 8'h99, 1'b0);
        wr(16'hF7F0, 8'hFE, 8'h3C, 1'b0);
        wr(16'h0020, 8'h00, 8'h00, 1'b1);
        rd_chk(16'h0020, 1'b0, 8'hFF);
        issue(fpo_pkg::CMD_ERASE, 16'h0000, 8'h00, 8'h00);
        check_flag("protected erase refused", 1'b1, err);
        rd_chk(16'h0010, 1'b0, 8'h00);
        wr(16'h0220, 8'h00, 8'h00, 1'b0);
        wr(16'hF7EC, 8'hFE, 8'h3C, 1'b0);
        rd_chk(16'h0600, 1'b1, 8'h00);
        rd_chk(16'h0800, 1'b0, 8'hFF);
        wr(16'hF7FF, 8'hF7, 8'h3C, 1'b0);
        wr(16'hF7F1, 8'h00, 8'h3C, 1'b1);
    endtask : sc_protection

    initial begin
        resetn     = 1'b0;
        n_errors   = 0;
        n_compared = 0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        check_flag("busy after reset", 1'b0, busy);
        check_flag("error after reset", 1'b0, error_q);
        check_byte("read data after reset", 8'h00, read_data_q);
        sc_erase_state();
        sc_program();
        sc_page_scope();
        sc_blocked();
        sc_protection();
        wrap_up();
    end
endmodule : flash_page_organization_protect_tb_top

// File: sim/fpo_cpu_model.sv
// processor-side model that issues flash commands through the command registers
`timescale 1ns/10ps
module fpo_cpu_model (
    input  wire logic       clock,        // system clock
    input  wire logic       busy,         // block busy, must stand together with done
    input  wire logic       done,         // completion pulse
    input  wire logic       error_q,      // refusal of last command
    input  wire logic       verify_ok_q,  // verify outcome
    input  wire logic [7:0] read_data_q,  // byte of last read
    output logic            cmd_valid,    // command register write strobe
    output logic      [2:0] cmd,          // command code
    output logic      [7:0] addr_hi,      // address high byte
    output logic      [7:0] addr_lo,      // address low byte
    output logic      [7:0] data,         // data byte
    output logic      [7:0] key           // offered protection key
);
    // idle values before the first command
    initial begin
        cmd_valid = 1'b0;
        cmd       = 3'h0;
        addr_hi   = 8'h00;
        addr_lo   = 8'h00;
        data      = 8'h00;
        key       = 8'h00;
    end

    // one command, fields held until done, then scrambled so stale values never help
    task automatic run_cmd(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d,
                           input logic [7:0] k, output logic err, output logic vok,
                           output logic [7:0] rd, output logic hung);
        int n;
        hung = 1'b1;
        err  = 1'b0;
        vok  = 1'b0;
        rd   = 8'h00;
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd       = c;
        addr_hi   = a[15:8];
        addr_lo   = a[7:0];
        data      = d;
        key       = k;
        @(negedge clock);
        cmd_valid = 1'b0;
        // bound covers a mass erase with margin
        for (n = 0; n < 70000 && hung === 1'b1; n++) begin
            if (done === 1'b1 && busy === 1'b1) begin
                hung = 1'b0;
                err  = error_q;
                vok  = verify_ok_q;
                rd   = read_data_q;
            end else begin
                @(negedge clock);
            end
        end
        @(negedge clock);
        cmd     = ~c;
        addr_hi = ~a[15:8];
        addr_lo = ~a[7:0];
        data    = ~d;
        key     = ~k;
    endtask : run_cmd
endmodule : fpo_cpu_model

// File: src/fpo_ctrl.sv
// flash sequencer: commands, page/mass erase, programming, verify and protection checks
`timescale 1ns/10ps
module fpo_ctrl (
    input  wire logic        clock,                  // 25 MHz system clock
    input  wire logic        resetn,                 // synchronous reset, active low
    input  wire logic        cmd_valid,              // one-cycle write of flash_command_reg
    input  wire logic [2:0]  flash_command_reg,      // command code
    input  wire logic [7:0]  flash_addr_high_reg,    // address high byte
    input  wire logic [7:0]  flash_addr_low_reg,     // address low byte
    input  wire logic [7:0]  flash_byte_reg,         // data byte for write and verify
    input  wire logic [7:0]  prot_key_in,            // key offered for protection changes
    output logic             busy,                   // command in progress
    output logic             done,                   // one-cycle completion pulse
    output logic             error_q,                // last command refused
    output logic             verify_ok_q,            // last verify matched
    output logic      [7:0]  read_data_q             // byte from last read
);
    fpo_pkg::fpo_state_t state_q;                    // sequencer state
    logic [2:0]  cmd_q;                              // latched command
    logic [15:0] addr_q;                             // latched address
    logic [7:0]  data_q;                             // latched data byte
    logic [15:0] cnt_q;                              // erase walk address
    logic [15:0] end_q;                              // erase walk last address
    logic        key_ok_q;                           // key absent or matched
    logic        mem_we;                             // array write strobe
    logic [15:0] mem_addr;                           // array address
    logic [7:0]  mem_wdata;                          // array write data
    logic [7:0]  rdata;                              // array read data
    logic [15:0] cmd_addr;                           // address offered with a command
    logic [6:0]  page;                               // page of latched address
    logic        is_we_op;                           // command is a write or a page erase
    logic        prot_bit;                           // selected protection bit
    logic        blocked;                            // checks refuse the command
    logic        cmd_legal;                          // one of the five codes

    assign cmd_addr  = {flash_addr_high_reg, flash_addr_low_reg};
    assign page      = addr_q[fpo_pkg::ADDR_W-1:fpo_pkg::PAGE_LSB];
    assign is_we_op  = (cmd_q == fpo_pkg::CMD_WRITE) || (cmd_q == fpo_pkg::CMD_ERASE);
    assign cmd_legal = (flash_command_reg >= fpo_pkg::CMD_READ) && (flash_command_reg <= fpo_pkg::CMD_MASS);
    assign busy      = (state_q != fpo_pkg::ST_IDLE);
    assign done      = (state_q == fpo_pkg::ST_DONE);

    // selected protection bit; 0 means protected so an erased area is open
    always_comb begin
        if (is_we_op) begin
            prot_bit = rdata[page[2:0]];
        end else begin
            prot_bit = rdata[page[4:2]];
        end
    end

    // refusal: protected page, or protection area touched without the key
    always_comb begin
        blocked = 1'b0;
        if (cmd_q == fpo_pkg::CMD_MASS) begin
            blocked = !key_ok_q;
        end else if (!prot_bit) begin
            blocked = 1'b1;
        end else if (cmd_q == fpo_pkg::CMD_WRITE && addr_q >= fpo_pkg::RSV_BASE) begin
            blocked = !key_ok_q;
        end else if (cmd_q == fpo_pkg::CMD_ERASE && page == fpo_pkg::TOP_PAGE) begin
            blocked = !key_ok_q;
        end
    end

    // array address and write data per state
    always_comb begin
        mem_addr  = addr_q;
        mem_we    = 1'b0;
        mem_wdata = rdata & data_q;
        unique case (state_q)
            fpo_pkg::ST_KEY:   mem_addr = fpo_pkg::KEY_ADDR;
            fpo_pkg::ST_PROT: begin
                if (is_we_op) begin
                    mem_addr = fpo_pkg::WE_BASE + {12'h000, page[6:3]};
                end else begin
                    mem_addr = fpo_pkg::RP_BASE + {14'h0000, page[6:5]};
                end
            end
            fpo_pkg::ST_OP:    mem_we = (cmd_q == fpo_pkg::CMD_WRITE);
            fpo_pkg::ST_ERASE: begin
                mem_addr  = cnt_q;
                mem_we    = 1'b1;
                mem_wdata = fpo_pkg::ERASED;
            end
            fpo_pkg::ST_IDLE, fpo_pkg::ST_CHK, fpo_pkg::ST_DONE: mem_addr = addr_q;
            default:           mem_addr = addr_q;
        endcase
    end

    fpo_mem #(
        .AW(fpo_pkg::ADDR_W),
        .DW(fpo_pkg::DATA_W)
    ) u_mem (
        .clock   (clock),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata_q (rdata)
    );

    // sequencer; commands are only taken while idle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= fpo_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                fpo_pkg::ST_IDLE: begin
                    if (cmd_valid) begin
                        if (!cmd_legal) begin
                            state_q <= fpo_pkg::ST_DONE;
                        end else if (flash_command_reg != fpo_pkg::CMD_MASS && cmd_addr >= fpo_pkg::FW_BASE) begin
                            state_q <= fpo_pkg::ST_DONE;
                        end else begin
                            state_q <= fpo_pkg::ST_KEY;
                        end
                    end
                end
                fpo_pkg::ST_KEY:   state_q <= fpo_pkg::ST_PROT;
                fpo_pkg::ST_PROT:  state_q <= fpo_pkg::ST_CHK;
                fpo_pkg::ST_CHK: begin
                    if (blocked) begin
                        state_q <= fpo_pkg::ST_DONE;
                    end else if (cmd_q == fpo_pkg::CMD_ERASE || cmd_q == fpo_pkg::CMD_MASS) begin
                        state_q <= fpo_pkg::ST_ERASE;
                    end else begin
                        state_q <= fpo_pkg::ST_OP;
                    end
                end
                fpo_pkg::ST_OP:    state_q <= fpo_pkg::ST_DONE;
                fpo_pkg::ST_ERASE: begin
                    if (cnt_q == end_q) begin
                        state_q <= fpo_pkg::ST_DONE;
                    end
                end
                fpo_pkg::ST_DONE:  state_q <= fpo_pkg::ST_IDLE;
                default:           state_q <= fpo_pkg::ST_IDLE;
            endcase
        end
    end

    // command capture from the byte and address registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cmd_q  <= 3'h0;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
        end else if (state_q == fpo_pkg::ST_IDLE && cmd_valid) begin
            cmd_q  <= flash_command_reg;
            addr_q <= cmd_addr;
            data_q <= flash_byte_reg;
        end
    end

    // key comparison; an erased key byte means no key is set
    always_ff @(posedge clock) begin
        if (!resetn) begin
            key_ok_q <= 1'b0;
        end else if (state_q == fpo_pkg::ST_PROT) begin
            key_ok_q <= (rdata == fpo_pkg::ERASED) || (rdata == prot_key_in);
        end
    end

    // erase walk: one page, or the whole user array; firmware never touched
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cnt_q <= 16'h0000;
            end_q <= 16'h0000;
        end else if (state_q == fpo_pkg::ST_CHK) begin
            if (cmd_q == fpo_pkg::CMD_MASS) begin
                cnt_q <= 16'h0000;
                end_q <= fpo_pkg::USER_TOP;
            end else begin
                cnt_q <= addr_q & ~fpo_pkg::PAGE_MASK;
                end_q <= addr_q | fpo_pkg::PAGE_MASK;
            end
        end else if (state_q == fpo_pkg::ST_ERASE) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // results: error, verify outcome and read data
    always_ff @(posedge clock) begin
        if (!resetn) begin
            error_q     <= 1'b0;
            verify_ok_q <= 1'b0;
            read_data_q <= 8'h00;
        end else begin
            if (state_q == fpo_pkg::ST_IDLE && cmd_valid) begin
                error_q <= !cmd_legal ||
                           (flash_command_reg != fpo_pkg::CMD_MASS && cmd_addr >= fpo_pkg::FW_BASE);
            end else if (state_q == fpo_pkg::ST_CHK) begin
                error_q <= blocked;
            end
            if (state_q == fpo_pkg::ST_OP && cmd_q == fpo_pkg::CMD_VERIFY) begin
                verify_ok_q <= (rdata == data_q);
            end
            if (state_q == fpo_pkg::ST_OP && cmd_q == fpo_pkg::CMD_READ) begin
                read_data_q <= rdata;
            end
        end
    end

    // checks
    chk_erase_ones: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_ERASE |-> mem_we && mem_wdata == fpo_pkg::ERASED)
        else $error("erase wrote a value other than all ones");
    chk_program_clears: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_OP && mem_we |-> (mem_wdata | rdata) == rdata)
        else $error("program set a bit back to one");
    chk_fw_untouched: assert property (@(posedge clock) disable iff (!resetn)
        mem_we |-> mem_addr < fpo_pkg::FW_BASE)
        else $error("firmware region written");
    chk_page_erase_span: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_ERASE && cmd_q == fpo_pkg::CMD_ERASE
        |-> cnt_q[fpo_pkg::ADDR_W-1:fpo_pkg::PAGE_LSB] == page)
        else $error("page erase left its page");
    chk_erase_finish: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_ERASE && cnt_q == end_q |=> state_q == fpo_pkg::ST_DONE)
        else $error("erase walk did not finish at its end");
    chk_verify_report: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_OP && cmd_q == fpo_pkg::CMD_VERIFY
        |=> done && verify_ok_q == ($past(rdata) == data_q))
        else $error("verify outcome wrong");
    chk_protect_ignore: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_CHK && is_we_op && !prot_bit |=> done && error_q ##1 !busy)
        else $error("protected page not refused");
    chk_key_guard: assert property (@(posedge clock) disable iff (!resetn)
        mem_we && mem_addr >= fpo_pkg::RSV_BASE && state_q == fpo_pkg::ST_OP |-> key_ok_q)
        else $error("protection area written without key");
    chk_read_protect: assert property (@(posedge clock) disable iff (!resetn)
        state_q == fpo_pkg::ST_CHK && cmd_q == fpo_pkg::CMD_READ && !prot_bit |=> error_q && done)
        else $error("read of protected group not refused");
endmodule : fpo_ctrl

// File: src/fpo_mem.sv
// byte-wide array storage with registered read data
`timescale 1ns/10ps
module fpo_mem #(
    parameter int unsigned AW = 16,              // address width
    parameter int unsigned DW = 8                // data width
) (
    input  wire logic          clock,            // system clock
    input  wire logic          we,               // write strobe
    input  wire logic [AW-1:0] addr,             // byte address
    input  wire logic [DW-1:0] wdata,            // write data
    output logic      [DW-1:0] rdata_q           // registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];            // storage, not reset: contents are nonvolatile

    // a fresh array starts erased, so the first key check never meets unknown contents
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = {DW{1'b1}};
        end
    end

    // write port
    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read port returns the old value on a write cycle
    always_ff @(posedge clock) begin
        rdata_q <= mem[addr];
    end
endmodule : fpo_mem

// File: src/fpo_pkg.sv
// constants and types shared by the flash page organization and protection block
// Summary of operation
// - erased bytes read back as 0xFF
// - programming only clears bits, one to zero
// - no byte erase, whole page only
// - 124 user pages of 512 bytes
// - page erase and mass erase supported
// - verify command compares the addressed byte with the data register
// - top 2 kB firmware region is blocked
// - last sixteen bytes hold per-page write protection
// - four bytes hold read protection per four pages
// - key byte must match to change protection
// - last 21 bytes of page 123 reserved
// - byte, address registers and five commands
package fpo_pkg;
    localparam int unsigned ADDR_W      = 16;            // byte address width of the 64 kB array
    localparam int unsigned DATA_W      = 8;             // flash byte width
    localparam int unsigned PAGE_LSB    = 9;             // 512-byte pages
    localparam int unsigned PAGE_W      = 7;             // page number width
    localparam logic [6:0]  USER_PAGES  = 7'h7C;         // 124 user pages
    localparam logic [6:0]  TOP_PAGE    = 7'h7B;         // page 123 holds protection
    localparam logic [15:0] FW_BASE     = 16'hF800;      // start of firmware region
    localparam logic [15:0] USER_TOP    = 16'hF7FF;      // last user byte
    localparam logic [15:0] PAGE_MASK   = 16'h01FF;      // in-page offset mask
    localparam logic [15:0] KEY_ADDR    = 16'hF7EB;      // key byte
    localparam logic [15:0] RP_BASE     = 16'hF7EC;      // four read-protect bytes
    localparam logic [15:0] WE_BASE     = 16'hF7F0;      // sixteen write/erase-protect bytes
    localparam logic [15:0] RSV_BASE    = 16'hF7EB;      // start of protection area
    localparam logic [7:0]  ERASED      = 8'hFF;         // erased byte value
    localparam logic [2:0]  CMD_READ    = 3'h1;          // read a byte
    localparam logic [2:0]  CMD_WRITE   = 3'h2;          // program a byte
    localparam logic [2:0]  CMD_VERIFY  = 3'h3;          // compare byte with data reg
    localparam logic [2:0]  CMD_ERASE   = 3'h4;          // erase addressed page
    localparam logic [2:0]  CMD_MASS    = 3'h5;          // erase whole user array

    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_KEY   = 8'h02,
        ST_PROT  = 8'h04,
        ST_CHK   = 8'h08,
        ST_OP    = 8'h10,
        ST_ERASE = 8'h20,
        ST_DONE  = 8'h40
    } fpo_state_t;
endpackage : fpo_pkg
